// ### core/adc_seq_pkg.sv
package adc_seq_pkg;

	////////////////////////////////////////////////////////////////////////////////
	// Register bus
	localparam int ADDR_W = 8;
	localparam int DATA_W = 8;

	localparam logic [7:0] PORT4_ANALOG_ADDR  = 8'hae;
	localparam logic [7:0] PORT12_ANALOG_ADDR = 8'haf;
	localparam logic [7:0] REF_CTRL_ADDR      = 8'hb0;
	localparam logic [7:0] CONV_CONTROL_ADDR  = 8'hb1;
	localparam logic [7:0] RESULT_HIGH_ADDR   = 8'hb2;
	localparam logic [7:0] CONV_MODE_ADDR     = 8'hb3;
	localparam logic [7:0] IRQ_CTRL_ADDR      = 8'hb4;

	////////////////////////////////////////////////////////////////////////////////
	// Field positions
	localparam int CC_POWER_BIT    = 7;
	localparam int CC_START_BIT    = 6;
	localparam int CC_DONE_BIT     = 5;
	localparam int CC_GATE_BIT     = 4;
	localparam int CC_CHAN_LSB     = 0;
	localparam int MODE_DIV_HI_BIT = 6;
	localparam int MODE_RES_BIT    = 5;
	localparam int MODE_DIV_LO_BIT = 4;
	localparam int REF_EXT_BIT     = 7;
	localparam int REF_LEVEL_LSB   = 0;
	localparam int IRQ_FLAG_BIT    = 0;
	localparam int IRQ_ENABLE_BIT  = 1;
	localparam int P1_PIN6_BIT     = 6;
	localparam int P1_PIN7_BIT     = 7;
	localparam int P2_PIN0_BIT     = 0;
	localparam int P2_PIN1_BIT     = 1;
	localparam int EXT_REF_PIN     = 0;

	////////////////////////////////////////////////////////////////////////////////
	// Reset values
	localparam logic [7:0]  PORT_ANALOG_RESET = 8'h00;
	localparam logic [3:0]  CHAN_RESET        = 4'h0;
	localparam logic [1:0]  DIV_RESET         = 2'h0;
	localparam logic [1:0]  REF_LEVEL_RESET   = 2'h0;
	localparam logic [11:0] RESULT_RESET      = 12'h000;

	////////////////////////////////////////////////////////////////////////////////
	// Clock divider codes and terminal counts
	localparam logic [1:0] DIV_BY_16 = 2'b00;
	localparam logic [1:0] DIV_BY_8  = 2'b01;
	localparam logic [1:0] DIV_BY_1  = 2'b10;
	localparam logic [1:0] DIV_BY_2  = 2'b11;
	localparam logic [3:0] DIV16_LAST = 4'(16 - 1);
	localparam logic [3:0] DIV8_LAST  = 4'(8 - 1);
	localparam logic [3:0] DIV1_LAST  = 4'(1 - 1);
	localparam logic [3:0] DIV2_LAST  = 4'(2 - 1);

	////////////////////////////////////////////////////////////////////////////////
	// Conversion length in ADC clock cycles
	localparam int CONV_PERIODS_8BIT     = 12;
	localparam int CONV_PERIODS_12BIT    = 16;
	localparam int ADC_CLOCKS_PER_PERIOD = 4;
	localparam logic [6:0] LAST_CYCLE_8BIT  = 7'(CONV_PERIODS_8BIT * ADC_CLOCKS_PER_PERIOD - 1);
	localparam logic [6:0] LAST_CYCLE_12BIT = 7'(CONV_PERIODS_12BIT * ADC_CLOCKS_PER_PERIOD - 1);

	localparam int NUM_CHANNELS = 12;

	typedef enum logic {
		CONV_IDLE,
		CONV_RUN
	} conv_state_e;

	function automatic logic reg_hit(
		input logic [7:0] addr,
		input logic [7:0] target,
		input logic       strobe
	);
		reg_hit = strobe && (addr == target);
	endfunction : reg_hit

endpackage : adc_seq_pkg

// ### core/conv_link_if.sv
`timescale 1ns/1ps
`default_nettype none

interface conv_link_if;
	logic [1:0]  divider_select;
	logic        run;
	logic        restart;
	logic        tick;
	logic [3:0]  channel_select;
	logic        channel_gate;
	logic [11:0] connect;

	modport ctrl    (output divider_select, output run, output restart, input tick,
	                 output channel_select, output channel_gate, input connect);
	modport divider (input divider_select, input run, input restart, output tick);
	modport mux     (input channel_select, input channel_gate, output connect);
endinterface : conv_link_if

`default_nettype wire

// ### core/adc_clock_divider.sv
`timescale 1ns/1ps
`default_nettype none

module adc_clock_divider
	import adc_seq_pkg::*;
(
	input  wire logic clock,
	input  wire logic srst,
	conv_link_if.divider link
);

	logic [3:0] count;
	logic [3:0] next_count;
	logic       tick;
	logic       next_tick;

	function automatic logic [3:0] last_count(input logic [1:0] code);
		unique case (code)
			DIV_BY_16: last_count = DIV16_LAST;
			DIV_BY_8:  last_count = DIV8_LAST;
			DIV_BY_1:  last_count = DIV1_LAST;
			DIV_BY_2:  last_count = DIV2_LAST;
		endcase
	endfunction : last_count

	// One tick per ADC clock period, phase restarted at every start
	always_comb begin
		next_count = count + 4'h1;
		next_tick  = 1'b0;
		if (link.restart || !link.run) begin
			next_count = 4'h0;
		end else if (count >= last_count(link.divider_select)) begin
			next_count = 4'h0;
			next_tick  = 1'b1;
		end
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			count <= 4'h0;
			tick  <= 1'b0;
		end else begin
			count <= next_count;
			tick  <= next_tick;
		end
	end

	assign link.tick = tick;

endmodule : adc_clock_divider

`default_nettype wire

// ### core/channel_mux.sv
`timescale 1ns/1ps
`default_nettype none

module channel_mux
	import adc_seq_pkg::*;
(
	input  wire logic clock,
	input  wire logic srst,
	conv_link_if.mux  link
);

	logic [NUM_CHANNELS-1:0] connect;
	logic [NUM_CHANNELS-1:0] next_connect;

	// Reserved codes connect nothing, so at most one input is ever joined
	for (genvar i = 0; i < NUM_CHANNELS; i++) begin : g_chan
		always_comb begin
			next_connect[i] = link.channel_gate && (link.channel_select == 4'(i));
		end
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			connect <= '0;
		end else begin
			connect <= next_connect;
		end
	end

	assign link.connect = connect;

endmodule : channel_mux

`default_nettype wire

// ### core/adc_sequencer_pin_config.sv
// Notes on behaviour
// - 8-bit conversion lasts 48 ADC clock cycles from start to done.
// - Divider code 01 gives clock/8, 10 gives clock/1, 11 gives clock/2.
// - Channel select value picks the analog input with that index.
// - At most one analog input is connected at any time.
// - Selected input connects only while the channel gate is one.
// - External reference enable makes port 4 pin 0 the high reference.
// - Port 4 analog-only bits cut digital use of matching port 4 pins.
// - Bits 7,6 serve port 1 pins 7,6; bits 1,0 serve port 2 pins 1,0.
// - A set analog-only bit isolates the pin's digital input path.
// - Start bit clears by itself when a conversion finishes.
// - Done bit sets when a conversion finishes and clears whenever start is written one, except by a power-zero write in the finishing cycle.
// - Each finished conversion sets the interrupt request flag.
// - Divider code 00 gives clock/16.
// - 12-bit conversion lasts 64 ADC clock cycles.
// - Resolution bit zero selects 8-bit, one selects 12-bit.
// - Result bits 11:4 in high byte, bits 3:0 in mode register low nibble.
//
// The address-and-strobe port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

module adc_sequencer_pin_config
	import adc_seq_pkg::*;
(
	input  wire logic        clock,
	input  wire logic        srst,
	input  wire logic [7:0]  reg_addr,
	input  wire logic [7:0]  reg_wdata,
	input  wire logic        reg_write,
	input  wire logic        reg_read,
	output var  logic [7:0]  reg_rdata,
	input  wire logic [11:0] converter_result,
	output var  logic        converter_power_enable,
	output var  logic        conv_busy,
	output var  logic        conv_clock_tick,
	output var  logic [11:0] analog_input_connect,
	output var  logic        reference_select,
	output var  logic [1:0]  reference_level,
	output var  logic [7:0]  port4_digital_disable,
	output var  logic [1:0]  port1_digital_disable,
	output var  logic [1:0]  port2_digital_disable,
	output var  logic        conv_irq_flag,
	output var  logic        conv_irq_request
);

	////////////////////////////////////////////////////////////////////////////////
	// Submodules

	conv_link_if link ();

	adc_clock_divider u_divider (
		.clock (clock),
		.srst  (srst),
		.link  (link)
	);

	channel_mux u_mux (
		.clock (clock),
		.srst  (srst),
		.link  (link)
	);

	////////////////////////////////////////////////////////////////////////////////
	// State

	conv_state_e state;
	conv_state_e next_state;
	logic [6:0]  conv_count;
	logic [6:0]  next_conv_count;
	logic        done;
	logic        next_done;
	logic        power;
	logic        next_power;
	logic        gate;
	logic        next_gate;
	logic [3:0]  chan;
	logic [3:0]  next_chan;
	logic [1:0]  div_sel;
	logic [1:0]  next_div_sel;
	logic        resolution_select;
	logic        next_resolution_select;
	logic [11:0] result;
	logic [11:0] next_result;
	logic        ext_ref;
	logic        next_ext_ref;
	logic [1:0]  ref_level;
	logic [1:0]  next_ref_level;
	logic        irq_enable;
	logic        next_irq_enable;
	logic        irq_flag;
	logic        next_irq_flag;
	logic        irq_request;
	logic        next_irq_request;
	logic [7:0]  port4_bits;
	logic [7:0]  next_port4_bits;
	logic [7:0]  port12_bits;
	logic [7:0]  next_port12_bits;
	logic [7:0]  rdata;
	logic [7:0]  next_rdata;
	logic        clock_tick;
	logic        next_clock_tick;
	logic        busy;
	logic        next_busy;
	logic [7:0]  port4_disable;
	logic [7:0]  next_port4_disable;

	logic        ctrl_write;
	logic        start_req;
	logic        finish;
	logic [6:0]  last_cycle;

	////////////////////////////////////////////////////////////////////////////////
	// Conversion sequencing

	assign ctrl_write = reg_hit(reg_addr, CONV_CONTROL_ADDR, reg_write);
	// Start needs the power bit set in the same write; power already on is not enough
	assign start_req  = ctrl_write && reg_wdata[CC_START_BIT] && reg_wdata[CC_POWER_BIT];
	assign last_cycle = resolution_select ? LAST_CYCLE_12BIT : LAST_CYCLE_8BIT;
	assign finish     = (state == CONV_RUN) && link.tick && !start_req
	                    && (conv_count == last_cycle);

	assign link.divider_select = div_sel;
	assign link.run            = (state == CONV_RUN);
	assign link.restart        = start_req;
	assign link.channel_select = chan;
	assign link.channel_gate   = gate;

	always_comb begin
		next_state      = state;
		next_conv_count = conv_count;
		next_done       = done;
		next_result     = result;
		if (state == CONV_RUN && link.tick) begin
			next_conv_count = conv_count + 7'h01;
		end
		if (finish) begin
			next_state      = CONV_IDLE;
			next_conv_count = 7'h00;
			next_result     = converter_result;
		end
		if (ctrl_write) begin
			if (!reg_wdata[CC_START_BIT] || !reg_wdata[CC_POWER_BIT]) begin
				next_state      = CONV_IDLE;
				next_conv_count = 7'h00;
			end
			if (reg_wdata[CC_START_BIT]) begin
				next_done = 1'b0;
			end else if (!reg_wdata[CC_DONE_BIT]) begin
				next_done = 1'b0;
			end
		end
		if (start_req) begin
			next_state      = CONV_RUN;
			next_conv_count = 7'h00;
		end
		if (finish) begin
			next_done = 1'b1;
		end
		next_busy = (next_state == CONV_RUN);
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			state      <= CONV_IDLE;
			conv_count <= 7'h00;
			done       <= 1'b0;
			result     <= RESULT_RESET;
			busy       <= 1'b0;
		end else begin
			state      <= next_state;
			conv_count <= next_conv_count;
			done       <= next_done;
			result     <= next_result;
			busy       <= next_busy;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Configuration registers

	always_comb begin
		next_power             = power;
		next_gate              = gate;
		next_chan              = chan;
		next_div_sel           = div_sel;
		next_resolution_select = resolution_select;
		next_ext_ref           = ext_ref;
		next_ref_level         = ref_level;
		next_irq_enable        = irq_enable;
		next_port4_bits        = port4_bits;
		next_port12_bits       = port12_bits;
		if (ctrl_write) begin
			next_power = reg_wdata[CC_POWER_BIT];
			next_gate  = reg_wdata[CC_GATE_BIT];
			next_chan  = reg_wdata[CC_CHAN_LSB +: 4];
		end
		if (reg_hit(reg_addr, CONV_MODE_ADDR, reg_write)) begin
			next_div_sel           = {reg_wdata[MODE_DIV_HI_BIT], reg_wdata[MODE_DIV_LO_BIT]};
			next_resolution_select = reg_wdata[MODE_RES_BIT];
		end
		if (reg_hit(reg_addr, REF_CTRL_ADDR, reg_write)) begin
			next_ext_ref   = reg_wdata[REF_EXT_BIT];
			next_ref_level = reg_wdata[REF_LEVEL_LSB +: 2];
		end
		if (reg_hit(reg_addr, IRQ_CTRL_ADDR, reg_write)) begin
			next_irq_enable = reg_wdata[IRQ_ENABLE_BIT];
		end
		if (reg_hit(reg_addr, PORT4_ANALOG_ADDR, reg_write)) begin
			next_port4_bits = reg_wdata;
		end
		if (reg_hit(reg_addr, PORT12_ANALOG_ADDR, reg_write)) begin
			next_port12_bits = reg_wdata;
		end
		// Pin 0 is also cut from digital use while it carries the reference
		next_port4_disable = {next_port4_bits[7:1],
		                      next_port4_bits[EXT_REF_PIN] | next_ext_ref};
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			power             <= 1'b0;
			gate              <= 1'b0;
			chan              <= CHAN_RESET;
			div_sel           <= DIV_RESET;
			resolution_select <= 1'b0;
			ext_ref           <= 1'b0;
			ref_level         <= REF_LEVEL_RESET;
			irq_enable        <= 1'b0;
			port4_bits        <= PORT_ANALOG_RESET;
			port12_bits       <= PORT_ANALOG_RESET;
			port4_disable     <= PORT_ANALOG_RESET;
		end else begin
			power             <= next_power;
			gate              <= next_gate;
			chan              <= next_chan;
			div_sel           <= next_div_sel;
			resolution_select <= next_resolution_select;
			ext_ref           <= next_ext_ref;
			ref_level         <= next_ref_level;
			irq_enable        <= next_irq_enable;
			port4_bits        <= next_port4_bits;
			port12_bits       <= next_port12_bits;
			port4_disable     <= next_port4_disable;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Interrupt flag, read port, registered outputs

	always_comb begin
		next_irq_flag = irq_flag;
		if (reg_hit(reg_addr, IRQ_CTRL_ADDR, reg_write)) begin
			next_irq_flag = reg_wdata[IRQ_FLAG_BIT];
		end
		// A finishing conversion wins over a clear in the same cycle
		if (finish) begin
			next_irq_flag = 1'b1;
		end
		next_irq_request = next_irq_flag && next_irq_enable;
		next_clock_tick  = link.tick;
	end

	always_comb begin
		next_rdata = 8'h00;
		if (reg_read) begin
			unique case (reg_addr)
				CONV_CONTROL_ADDR: begin
					next_rdata = {power, (state == CONV_RUN), done, gate, chan};
				end
				RESULT_HIGH_ADDR: begin
					next_rdata = result[11:4];
				end
				CONV_MODE_ADDR: begin
					next_rdata = {1'b0, div_sel[1], resolution_select, div_sel[0],
					              result[3:0]};
				end
				REF_CTRL_ADDR: begin
					next_rdata = {ext_ref, 5'h00, ref_level};
				end
				IRQ_CTRL_ADDR: begin
					next_rdata = {6'h00, irq_enable, irq_flag};
				end
				default: begin
					next_rdata = 8'h00;
				end
			endcase
		end
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			irq_flag    <= 1'b0;
			irq_request <= 1'b0;
			rdata       <= 8'h00;
			clock_tick  <= 1'b0;
		end else begin
			irq_flag    <= next_irq_flag;
			irq_request <= next_irq_request;
			rdata       <= next_rdata;
			clock_tick  <= next_clock_tick;
		end
	end

	assign reg_rdata              = rdata;
	assign converter_power_enable = power;
	assign conv_busy              = busy;
	assign conv_clock_tick        = clock_tick;
	assign analog_input_connect   = link.connect;
	assign reference_select       = ext_ref;
	assign reference_level        = ref_level;
	assign port4_digital_disable  = port4_disable;
	assign port1_digital_disable  = {port12_bits[P1_PIN7_BIT], port12_bits[P1_PIN6_BIT]};
	assign port2_digital_disable  = {port12_bits[P2_PIN1_BIT], port12_bits[P2_PIN0_BIT]};
	assign conv_irq_flag          = irq_flag;
	assign conv_irq_request       = irq_request;

endmodule : adc_sequencer_pin_config

`default_nettype wire

// ### verif/adc_seq_chk.sv
`timescale 1ns/1ps
`default_nettype none

module adc_seq_chk
	import adc_seq_pkg::*;
(
	input wire logic        clock,
	input wire logic        srst,
	input wire logic [7:0]  reg_addr,
	input wire logic [7:0]  reg_wdata,
	input wire logic        reg_write,
	input wire logic        reg_read,
	input wire logic [7:0]  reg_rdata,
	input wire logic        conv_busy,
	input wire logic [11:0] analog_input_connect,
	input wire logic        reference_select,
	input wire logic [7:0]  port4_digital_disable,
	input wire logic [1:0]  port1_digital_disable,
	input wire logic [1:0]  port2_digital_disable,
	input wire logic        conv_irq_flag
);
	default clocking @(posedge clock); endclocking
	default disable iff (srst);

	logic cc_wr;
	logic p4_wr;
	logic p12_wr;
	assign cc_wr  = reg_write && reg_addr == CONV_CONTROL_ADDR;
	assign p4_wr  = reg_write && reg_addr == PORT4_ANALOG_ADDR;
	assign p12_wr = reg_write && reg_addr == PORT12_ANALOG_ADDR;

	////////////////////////////////////////////////////////////////
	a_start_busy: assert property (cc_wr && reg_wdata[7] && reg_wdata[6] |=> conv_busy)
		else $error("start did not raise busy");
	a_unpowered_idle: assert property (cc_wr && !reg_wdata[7] |=> !conv_busy)
		else $error("busy without power");
	a_connect_onehot: assert property ($onehot0(analog_input_connect))
		else $error("more than one input connected");
	a_gate_off: assert property (cc_wr && !reg_wdata[4] |-> ##2 analog_input_connect == 12'h000)
		else $error("input connected with gate off");
	a_chan_pick: assert property (cc_wr && reg_wdata[4] && reg_wdata[3:0] < 4'hc
		|-> ##2 analog_input_connect == 12'h001 << $past(reg_wdata[3:0], 2))
		else $error("wrong input connected");
	a_finish_flag: assert property ($fell(conv_busy) && !$past(reg_write) |-> conv_irq_flag)
		else $error("finish without flag");
	a_ref_isolate: assert property (reference_select && $past(reference_select)
		|-> port4_digital_disable[0])
		else $error("reference pin not isolated");
	a_port4_bits: assert property (p4_wr |=> port4_digital_disable[7:1] == $past(reg_wdata[7:1]))
		else $error("port4 isolation mismatch");
	a_port12_bits: assert property (p12_wr |=> {port1_digital_disable, port2_digital_disable}
		== {$past(reg_wdata[7:6]), $past(reg_wdata[1:0])})
		else $error("port1 port2 isolation mismatch");
	a_wo_reads: assert property (reg_read && (reg_addr == PORT4_ANALOG_ADDR
		|| reg_addr == PORT12_ANALOG_ADDR) |=> reg_rdata == 8'h00)
		else $error("write-only register read nonzero");

	c_start: cover property (cc_wr && reg_wdata[7] && reg_wdata[6]);
	c_pick: cover property (cc_wr && reg_wdata[4] && reg_wdata[3:0] == 4'hb);
	c_finish: cover property ($rose(conv_irq_flag));
endmodule : adc_seq_chk

`default_nettype wire

// ### verif/conv_core_model.sv
`timescale 1ns/1ps
`default_nettype none

module conv_core_model (
	input  wire logic        clock,
	input  wire logic        busy,
	input  wire logic [11:0] connect,
	input  wire logic [7:0]  level,
	output var  logic [11:0] result
);
	initial result = 12'h000;

	// Holds the connected input's sample while converting, toggles while idle
	always @(posedge clock) begin
		if (busy) begin
			result <= {4'h0, level};
			for (int i = 0; i < 12; i++)
				if (connect[i])
					result <= {4'(i), level};
		end else
			result <= ~result;
	end
endmodule : conv_core_model

`default_nettype wire

// ### verif/adc_sequencer_pin_config_bench.sv
`timescale 1ns/1ps
`default_nettype none

module adc_sequencer_pin_config_bench
	import adc_seq_pkg::*;
;
	logic        clock = 1'b0;
	logic        srst = 1'b1;
	logic [7:0]  reg_addr = 8'h00;
	logic [7:0]  reg_wdata = 8'h00;
	logic        reg_write = 1'b0;
	logic        reg_read = 1'b0;
	logic [7:0]  level = 8'h00;
	logic [7:0]  reg_rdata;
	logic [11:0] result;
	logic [11:0] connect;
	logic        power, busy, tick, ref_sel, flag, irq_req, en;
	logic [1:0]  ref_level, p1_dis, p2_dis;
	logic [7:0]  p4_dis, d;
	logic [11:0] er;
	int          n_errors = 0;
	int          n_compared = 0;
	int          cyc_now = 0;
	int          g, n, e, t0, n_ticks;
	logic [7:0]  regs [8] = '{8'hb0, 8'hb1, 8'hb2, 8'hb3, 8'hb4, 8'hae, 8'haf, 8'hc0};

	always #4 clock = ~clock;
	always @(posedge clock) cyc_now <= cyc_now + 1;

	adc_sequencer_pin_config adc_sequencer_pin_config_inst (
		.clock(clock), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
		.converter_result(result), .converter_power_enable(power), .conv_busy(busy),
		.conv_clock_tick(tick), .analog_input_connect(connect), .reference_select(ref_sel),
		.reference_level(ref_level), .port4_digital_disable(p4_dis),
		.port1_digital_disable(p1_dis), .port2_digital_disable(p2_dis),
		.conv_irq_flag(flag), .conv_irq_request(irq_req)
	);

	conv_core_model conv_core_model_inst (
		.clock(clock), .busy(busy), .connect(connect), .level(level), .result(result)
	);

	////////////////////////////////////////////////////////////////
	task automatic close_out();
		if (n_errors == 0 && n_compared > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : close_out

	task automatic check(string what, logic [15:0] exp, logic [15:0] got);
		n_compared++;
		if (got !== exp) begin
			n_errors++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask : check

	task automatic cyc(int k);
		repeat (k) @(posedge clock);
		#1;
	endtask : cyc

	task automatic wr(logic [7:0] a, logic [7:0] v);
		@(posedge clock);
		reg_write <= 1'b1;
		reg_addr  <= a;
		reg_wdata <= v;
		@(posedge clock);
		reg_write <= 1'b0;
	endtask : wr

	task automatic rd(logic [7:0] a, logic [7:0] exp, string what);
		@(posedge clock);
		reg_read <= 1'b1;
		reg_addr <= a;
		@(posedge clock);
		reg_read <= 1'b0;
		#1;
		check(what, {8'h00, exp}, {8'h00, reg_rdata});
	endtask : rd

	////////////////////////////////////////////////////////////////
	initial begin
		void'($urandom(68));
		repeat (12) @(posedge clock);
		srst <= 1'b0;
		foreach (regs[i]) rd(regs[i], 8'h00, "reset value");
		wr(8'hc0, 8'hff);
		rd(8'hc0, 8'h00, "unmapped");
		for (int i = 0; i < 4; i++) begin
			d = 8'($urandom);
			wr(PORT4_ANALOG_ADDR, d);
			wr(PORT12_ANALOG_ADDR, ~d);
			cyc(1);
			check("port4 isolate", {8'h0, d}, {8'h0, p4_dis});
			check("port12 isolate", {12'h0, ~d[7:6], ~d[1:0]}, {12'h0, p1_dis, p2_dis});
			rd(PORT12_ANALOG_ADDR, 8'h00, "port12 readback");
		end
		wr(PORT4_ANALOG_ADDR, 8'h00);
		wr(PORT12_ANALOG_ADDR, 8'h00);
		cyc(1);
		check("isolation off", 16'h0, {4'h0, p4_dis, p1_dis, p2_dis});
		wr(REF_CTRL_ADDR, 8'h82);
		cyc(2);
		check("ref route", 16'h000d, {12'h0, ref_sel, ref_level, p4_dis[0]});
		rd(REF_CTRL_ADDR, 8'h82, "ref readback");
		wr(REF_CTRL_ADDR, 8'h00);
		for (int c = 0; c < 32; c++) begin
			wr(CONV_CONTROL_ADDR, {3'b000, c < 16, 4'(c)});
			cyc(2);
			check("connect", 16'(c < 12 ? 1 << c : 0), {4'h0, connect});
		end
		wr(CONV_CONTROL_ADDR, 8'h40);
		cyc(3);
		check("unpowered start", 16'h0, {15'h0, busy});
		wr(PORT4_ANALOG_ADDR, 8'hfc);
		wr(PORT12_ANALOG_ADDR, 8'h03);
		wr(CONV_CONTROL_ADDR, 8'h80);
		repeat (12500) @(posedge clock);
		for (int k = 0; k < 8; k++) begin
			en = k[2] ^ k[0];
			@(posedge clock);
			level <= 8'($urandom);
			wr(IRQ_CTRL_ADDR, {6'h0, en, 1'b0});
			wr(CONV_MODE_ADDR, {1'b0, k[1], k[2], k[0], 4'h0});
			wr(CONV_CONTROL_ADDR, 8'hd0 | 8'(k + 2));
			if (k == 3) begin
				cyc(5);
				wr(CONV_CONTROL_ADDR, 8'hd0 | 8'(k + 2));
			end
			rd(CONV_CONTROL_ADDR, 8'hd0 | 8'(k + 2), "busy at start");
			t0 = cyc_now;
			g = 0;
			n_ticks = (tick === 1'b1) ? 1 : 0;
			while (busy === 1'b1 && g < 2000) begin
				cyc(1);
				g++;
				if (tick === 1'b1)
					n_ticks++;
			end
			n = (k[2] ? 64 : 48) * (k[1:0] == 0 ? 16 : k[1:0] == 1 ? 8 : k[1:0] == 2 ? 1 : 2);
			e = cyc_now - t0 + 2;
			check("length", 16'(n), (e >= n - 1 && e <= n + 3) ? 16'(n) : 16'(e));
			check("ticks", 16'(k[2] ? 64 : 48), 16'(n_ticks));
			er = {4'(k + 2), level};
			rd(RESULT_HIGH_ADDR, er[11:4], "result high");
			rd(CONV_MODE_ADDR, {1'b0, k[1], k[2], k[0], er[3:0]}, "mode");
			rd(CONV_CONTROL_ADDR, 8'hb0 | 8'(k + 2), "done status");
			rd(IRQ_CTRL_ADDR, {6'h0, en, 1'b1}, "irq reg");
			check("irq request", {15'h0, en}, {15'h0, irq_req});
			wr(IRQ_CTRL_ADDR, 8'h00);
			cyc(1);
			check("flag clear", 16'h0, {15'h0, flag});
		end
		wr(CONV_CONTROL_ADDR, 8'hd2);
		cyc(5);
		wr(CONV_CONTROL_ADDR, 8'h92);
		cyc(1);
		check("abort", 16'h0, {15'h0, busy});
		wr(CONV_CONTROL_ADDR, 8'hd2);
		repeat (10) @(posedge clock);
		srst <= 1'b1;
		repeat (2) @(posedge clock);
		srst <= 1'b0;
		cyc(1);
		check("mid reset", 16'h0, {13'h0, busy, flag, power});
		rd(CONV_CONTROL_ADDR, 8'h00, "control after reset");
		wr(CONV_CONTROL_ADDR, 8'h80);
		cyc(1);
		check("power on", 16'h1, {15'h0, power});
		wr(CONV_CONTROL_ADDR, 8'h00);
		cyc(1);
		check("power off", 16'h0, {15'h0, power});
		close_out();
	end

	initial begin
		#(8 * 50000);
		n_errors++;
		close_out();
	end
endmodule : adc_sequencer_pin_config_bench

bind adc_sequencer_pin_config adc_seq_chk adc_seq_chk_inst (
	.clock(clock), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
	.reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
	.conv_busy(conv_busy), .analog_input_connect(analog_input_connect),
	.reference_select(reference_select), .port4_digital_disable(port4_digital_disable),
	.port1_digital_disable(port1_digital_disable),
	.port2_digital_disable(port2_digital_disable), .conv_irq_flag(conv_irq_flag)
);

`default_nettype wire
